//--- logic/arb_table_cfg.svh
`ifndef ARB_TABLE_CFG_SVH
`define ARB_TABLE_CFG_SVH

// register byte addresses
`define ADDR_TABLE_WORD0 12'h220
`define ADDR_TABLE_WORD1 12'h224
`define ADDR_TABLE_WORD2 12'h228
`define ADDR_VC_CONTROL 12'h214
`define ADDR_VC_STATUS 12'h218
// field positions
`define SLOT_WIDTH 4
`define SLOTS_PER_WORD 8
`define NUM_SLOTS 24
`define CTL_LOAD_BIT 16
`define STS_DIRTY_BIT 16
// reset values and codes
`define TABLE_RESET 32'h0000_0000
`define LAST_VALID_PORT 4'h6
`define LOAD_CYCLES 5'h18
// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- logic/arb_table_pkg.sv
package arb_table_pkg;
  typedef logic [3:0] slot_code_t;
  typedef logic [4:0] slot_idx_t;
  typedef enum logic [2:0] {
    LD_IDLE = 3'h1,
    LD_BUSY = 3'h2,
    LD_DONE = 3'h4
  } load_state_t;
endpackage

//--- logic/slot_decode.sv
`include "arb_table_cfg.svh"

// turns one slot code into a valid flag and a one-hot port select
module slot_decode
  import arb_table_pkg::*;
(
  input wire arb_table_pkg::slot_code_t code,
  output logic valid,
  output logic [6:0] port_sel
);
  // codes above the last port are reserved and select nothing
  always_comb begin
    valid = (code <= `LAST_VALID_PORT);
    port_sel = 7'h00;
    if (valid) begin
      port_sel[code[2:0]] = 1'b1;
    end
  end
endmodule

//--- logic/port_arbitration_table.sv
// Functional notes
// - each nibble slot names the ingress port served in that arbitration period
// - arbiter skips slots with an invalid port code without spending a period
// - code 0 is upstream port zero, codes 1..6 downstream ports 1..6
// - codes 7 to F are reserved and select no port
// - word 0 holds slots 0..7, slot 0 in bits 3:0
// - word 1 holds slots 8..15 in ascending nibbles
// - word 2 holds slots 16..23; all fields read/write, reset zero
// - a table write sets dirty flag until a requested load finishes
// - dirty flag always reads zero on downstream ports
`include "arb_table_cfg.svh"

module port_arbitration_table
  import arb_table_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic is_downstream,
  input wire logic arb_advance,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output arb_table_pkg::slot_idx_t arb_slot_idx,
  output arb_table_pkg::slot_code_t arb_port_id,
  output logic [6:0] arb_port_sel,
  output logic arb_grant_valid,
  output logic table_dirty_flag
);
  typedef struct packed {
    // table words, reset zero
    logic [31:0] word0;
    logic [31:0] word1;
    logic [31:0] word2;
    // write address and data holding registers
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // write response
    logic bvalid;
    logic [1:0] bresp;
    // read response
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // coherency flag and load sequencer
    logic dirty;
    load_state_t ld_state;
    logic [4:0] ld_cnt;
    // arbiter outputs
    slot_idx_t cur_slot;
    slot_code_t port_id;
    logic [6:0] port_sel;
    logic grant_valid;
    // strap synchroniser
    logic down_s1;
    logic down_s2;
    // registered bus ready and flag outputs
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic dirty_out;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  // flattened table and per-slot decode
  logic [`NUM_SLOTS*`SLOT_WIDTH-1:0] table_flat;
  slot_code_t slot_code [`NUM_SLOTS];
  logic [`NUM_SLOTS-1:0] slot_ok;
  logic [6:0] slot_sel [`NUM_SLOTS];
  // arbiter search results
  slot_idx_t next_slot;
  logic next_found;
  // bus decode
  logic wr_fire;
  logic wr_hit;
  logic ctl_load;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic rd_hit;

  // slot n sits in word n/8 at nibble n%8
  assign table_flat = {state_r.word2, state_r.word1, state_r.word0};

  // one decoder per slot
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_SLOTS; gi = gi + 1) begin : g_dec
      assign slot_code[gi] = table_flat[gi*`SLOT_WIDTH +: `SLOT_WIDTH];
      slot_decode u_dec (
        .code(slot_code[gi]),
        .valid(slot_ok[gi]),
        .port_sel(slot_sel[gi])
      );
    end
  endgenerate

  // search forward from the current slot for the next valid entry
  // a full turn is scanned so a lone valid slot is found again
  always_comb begin
    slot_idx_t cand;
    cand = 5'h00;
    next_slot = state_r.cur_slot;
    next_found = 1'b0;
    // invalid slots skipped in the same cycle
    for (int k = 1; k <= `NUM_SLOTS; k++) begin
      cand = 5'((int'(state_r.cur_slot) + k) % `NUM_SLOTS);
      if (!next_found && slot_ok[cand]) begin
        next_slot = cand;
        next_found = 1'b1;
      end
    end
  end

  // byte lane mask for writes
  // strobe lanes keep untouched bytes of a word
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{state_r.w_strb[b]}};
    end
  end

  // write decode once address and data are both held
  // a write waits while its response is unanswered, one at a time
  assign wr_fire = state_r.aw_held && state_r.w_held && !state_r.bvalid;
  assign wr_hit = (state_r.aw_addr[11:2] == `ADDR_TABLE_WORD0 >> 2) ||
                  (state_r.aw_addr[11:2] == `ADDR_TABLE_WORD1 >> 2) ||
                  (state_r.aw_addr[11:2] == `ADDR_TABLE_WORD2 >> 2);
  assign ctl_load = wr_fire && (state_r.aw_addr[11:2] == `ADDR_VC_CONTROL >> 2) &&
                    state_r.w_strb[2] && state_r.w_data[`CTL_LOAD_BIT];

  // read mux
  // read data latched from the address at the taking edge
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr[11:2])
      `ADDR_TABLE_WORD0 >> 2: rd_val = state_r.word0;
      `ADDR_TABLE_WORD1 >> 2: rd_val = state_r.word1;
      `ADDR_TABLE_WORD2 >> 2: rd_val = state_r.word2;
      `ADDR_VC_CONTROL >> 2: rd_val = 32'h0000_0000;
      // flag forced low on downstream ports
      `ADDR_VC_STATUS >> 2: rd_val[`STS_DIRTY_BIT] = state_r.dirty && !state_r.down_s2;
      default: rd_hit = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    state_nxt = state_r;
    // strap passes two flops before use
    state_nxt.down_s1 = is_downstream;
    state_nxt.down_s2 = state_r.down_s1;
    // address and data captured independently
    if (s_axi_awvalid && !state_r.aw_held) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_r.w_held) begin
      state_nxt.w_held = 1'b1;
      state_nxt.w_data = s_axi_wdata;
      state_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = (wr_hit || state_r.aw_addr[11:2] == `ADDR_VC_CONTROL >> 2)
                        ? `RESP_OKAY : `RESP_SLVERR;
      // read/write slot fields with byte lanes
      if (state_r.aw_addr[11:2] == `ADDR_TABLE_WORD0 >> 2) begin
        state_nxt.word0 = (state_r.word0 & ~wmask) | (state_r.w_data & wmask);
      end
      if (state_r.aw_addr[11:2] == `ADDR_TABLE_WORD1 >> 2) begin
        state_nxt.word1 = (state_r.word1 & ~wmask) | (state_r.w_data & wmask);
      end
      if (state_r.aw_addr[11:2] == `ADDR_TABLE_WORD2 >> 2) begin
        state_nxt.word2 = (state_r.word2 & ~wmask) | (state_r.w_data & wmask);
      end
    end
    if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end
    // read answered one cycle after address
    // a new read waits until the last answer is taken
    if (s_axi_arvalid && !state_r.rvalid) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rdata = rd_val;
      state_nxt.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end
    // table load sequence
    // busy counts down the load time, done is a one-cycle pulse
    case (state_r.ld_state)
      LD_IDLE: begin
        if (ctl_load) begin
          state_nxt.ld_state = LD_BUSY;
          state_nxt.ld_cnt = `LOAD_CYCLES;
        end
      end
      LD_BUSY: begin
        state_nxt.ld_cnt = state_r.ld_cnt - 5'h01;
        if (state_r.ld_cnt == 5'h01) begin
          state_nxt.ld_state = LD_DONE;
        end
      end
      LD_DONE: state_nxt.ld_state = LD_IDLE;
      default: state_nxt.ld_state = LD_IDLE;
    endcase
    // dirty on write, cleared by load done; write wins
    // clear first so a write in the done cycle keeps the flag set
    if (state_r.ld_state == LD_DONE) begin
      state_nxt.dirty = 1'b0;
    end
    if (wr_fire && wr_hit && (state_r.w_strb != 4'h0)) begin
      state_nxt.dirty = 1'b1;
    end
    // advance one period per request to next valid slot
    // with no valid slot the index holds and the select drops
    if (arb_advance) begin
      state_nxt.grant_valid = next_found;
      if (next_found) begin
        state_nxt.cur_slot = next_slot;
        state_nxt.port_id = slot_code[next_slot];
        state_nxt.port_sel = slot_sel[next_slot];
      end else begin
        state_nxt.port_sel = 7'h00;
      end
    end
    // ready outputs registered from the next holding state
    state_nxt.aw_rdy = !state_nxt.aw_held;
    state_nxt.w_rdy = !state_nxt.w_held;
    state_nxt.ar_rdy = !state_nxt.rvalid;
    state_nxt.dirty_out = state_nxt.dirty && !state_nxt.down_s2;
  end

  // registers
  // reset parks the index on the last slot so slot zero comes first
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= '0;
      state_r.ld_state <= LD_IDLE;
      state_r.cur_slot <= 5'(`NUM_SLOTS - 1);
      state_r.aw_rdy <= 1'b1;
      state_r.w_rdy <= 1'b1;
      state_r.ar_rdy <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = state_r.aw_rdy;
  assign s_axi_wready = state_r.w_rdy;
  assign s_axi_bvalid = state_r.bvalid;
  assign s_axi_bresp = state_r.bresp;
  assign s_axi_arready = state_r.ar_rdy;
  assign s_axi_rvalid = state_r.rvalid;
  assign s_axi_rdata = state_r.rdata;
  assign s_axi_rresp = state_r.rresp;
  assign arb_slot_idx = state_r.cur_slot;
  assign arb_port_id = state_r.port_id;
  assign arb_port_sel = state_r.port_sel;
  assign arb_grant_valid = state_r.grant_valid;
  assign table_dirty_flag = state_r.dirty_out;
endmodule

//--- tb/arb_table_assertions.sv
module arb_table_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic is_downstream,
  input wire logic arb_advance,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire arb_table_pkg::slot_idx_t arb_slot_idx,
  input wire arb_table_pkg::slot_code_t arb_port_id,
  input wire logic [6:0] arb_port_sel,
  input wire logic arb_grant_valid,
  input wire logic table_dirty_flag
);
  import arb_table_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // arbiter output relations
  chk_sel_onehot: assert property (arb_grant_valid |-> arb_port_sel == 7'h01 << arb_port_id)
    else $error("select is not the one-hot of the port");
  chk_no_reserved: assert property (arb_grant_valid ? arb_port_id <= 4'h6 : arb_port_sel == '0)
    else $error("reserved code selects a port");
  chk_idle_hold: assert property (!arb_advance |=> $stable(arb_slot_idx) && $stable(arb_port_sel))
    else $error("slot moved without advance");
  chk_slot_range: assert property (arb_slot_idx <= 5'h17)
    else $error("slot index past last slot");
  chk_empty_hold: assert property (arb_advance ##1 !arb_grant_valid |-> $stable(arb_slot_idx))
    else $error("slot moved with no valid slot");
  // coherency flag and register path
  chk_strap_clear: assert property (is_downstream [*4] |-> !table_dirty_flag)
    else $error("dirty flag set on downstream port");
  chk_write_dirty: assert property (!is_downstream [*4] ##0 (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready && s_axi_wstrb != 4'h0
    && s_axi_awaddr inside {12'h220, 12'h224, 12'h228}) |-> ##[1:3] table_dirty_flag)
    else $error("table write left dirty flag clear");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_reset_clean: assert property ($fell(srst) |-> !table_dirty_flag && !arb_grant_valid
    && arb_slot_idx == 5'h17)
    else $error("outputs not clean after reset");
endmodule

bind port_arbitration_table arb_table_assertions arb_table_assertions_inst (.clk(clk),
  .srst(srst), .is_downstream(is_downstream), .arb_advance(arb_advance),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .arb_slot_idx(arb_slot_idx), .arb_port_id(arb_port_id), .arb_port_sel(arb_port_sel),
  .arb_grant_valid(arb_grant_valid), .table_dirty_flag(table_dirty_flag));

//--- tb/port_arbitration_table_tb_top.sv
module port_arbitration_table_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import arb_table_pkg::*;
  logic clk = 1'h0, srst = 1'h1, is_downstream = 1'h0, arb_advance = 1'h0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ok;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic arb_grant_valid, table_dirty_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [6:0] arb_port_sel;
  slot_idx_t arb_slot_idx;
  slot_code_t arb_port_id;
  slot_code_t tbl [24];
  logic [31:0] pat [3] = '{32'h7654_3210, 32'hFEDC_BA98, 32'h6A5B_4C3D};
  int n_fail = 0, comparisons = 0, cur = 23, k;
  always #50 clk = ~clk;
  port_arbitration_table port_arbitration_table_inst (.clk(clk), .srst(srst),
    .is_downstream(is_downstream), .arb_advance(arb_advance), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .arb_slot_idx(arb_slot_idx), .arb_port_id(arb_port_id),
    .arb_port_sel(arb_port_sel), .arb_grant_valid(arb_grant_valid),
    .table_dirty_flag(table_dirty_flag));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // bus write, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // handshakes judged on settled values before the edge
    do begin
      @(negedge clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_hs) s_axi_awvalid <= 1'h0;
      if (w_hs) s_axi_wvalid <= 1'h0;
    end while (!b_hs);
    s_axi_bready <= 1'h0;
  endtask
  // bus read
  task automatic rdw(input logic [11:0] a);
    logic ar_hs, r_hs;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar_hs) s_axi_arvalid <= 1'h0;
    end while (!r_hs);
    s_axi_rready <= 1'h0;
  endtask
  // next valid slot, ascending with wrap, then compare
  task automatic step();
    ok = 1'h0;
    for (int i = 1; i <= 24 && !ok; i++) begin
      ok = tbl[(cur + i) % 24] <= 4'h6;
      if (ok) cur = (cur + i) % 24;
    end
    chk("grant", 32'(ok), 32'(arb_grant_valid));
    chk("slot", cur, 32'(arb_slot_idx));
    chk("sel", ok ? 32'h1 << tbl[cur] : '0, 32'(arb_port_sel));
    if (ok) chk("port", 32'(tbl[cur]), 32'(arb_port_id));
  endtask
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    for (k = 0; k < 3; k++) begin
      rdw(12'h220 + 12'(4 * k));
      chk("reset word", '0, rd);
      // egress id kept out of use; reserved codes only probe the skip
      wr(12'h220 + 12'(4 * k), pat[k]);
      for (int j = 0; j < 8; j++) tbl[8 * k + j] = pat[k][4 * j +: 4];
      rdw(12'h220 + 12'(4 * k));
      chk("table word", pat[k], rd);
    end
    rdw(12'h218);
    chk("dirty set", 32'h0001_0000, rd & 32'h0001_0000);
    @(posedge clk);
    arb_advance <= 1'h1;
    for (k = 0; k < 30; k++) begin
      @(posedge clk);
      if (k == 29) arb_advance <= 1'h0;
      #1 step();
    end
    wr(12'h214, 32'h0001_0000);
    repeat (30) @(posedge clk);
    rdw(12'h218);
    chk("dirty clear", '0, rd & 32'h0001_0000);
    rdw(12'h230);
    chk("unmapped resp", 32'h2, 32'(resp));
    chk("unmapped data", '0, rd);
    @(posedge clk);
    is_downstream <= 1'h1;
    repeat (4) @(posedge clk);
    wr(12'h220, 32'h0000_0001);
    rdw(12'h218);
    chk("downstream flag", '0, rd & 32'h0001_0000);
    // whole table reserved: advance finds nothing
    for (k = 0; k < 3; k++) begin
      wr(12'h220 + 12'(4 * k), 32'hFFFF_FFFF);
      for (int j = 0; j < 8; j++) tbl[8 * k + j] = 4'hF;
    end
    @(posedge clk);
    arb_advance <= 1'h1;
    @(posedge clk);
    arb_advance <= 1'h0;
    #1 step();
    conclude();
  end
endmodule
